// [inc/uart_sdam_params.svh]
// constants for the serial status, data holding and node match block
// assumes a 12-bit byte-wide register port and a 100 MHz system clock
`ifndef UART_SDAM_PARAMS_SVH
`define UART_SDAM_PARAMS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_DATA 12'hf40
`define OFS_FLAGS1 12'hf41
`define OFS_CTRL 12'hf42
`define OFS_FLAGS2 12'hf44
`define OFS_NODE 12'hf45
`define OFS_IRQ_STAT 12'hf48
`define OFS_IRQ_MASK 12'hf49
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_NODE 8'h00
`define RST_CTRL 8'h00
`define RST_MASK 4'h0
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_PAR_ON 0
`define CTRL_PAR_ODD 1
`define CTRL_MODE 2
`define CTRL_SEL 4:3
`define CTRL_TXMP 5
`define F2_SPARE 3:2
`define IRQ_RX 0
`define IRQ_ERR 1
`define IRQ_TX_HOLDING_EMPTY_FLAG 2
`define IRQ_TXDONE 3
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define BIT_TIME_NS 8680
`define BIT_CYCLES (`BIT_TIME_NS / `CLK_PERIOD_NS)
`endif

// [inc/uart_sdam_pkg.sv]
// types for the serial status, data holding and node match block
// assumes nothing beyond a standard SystemVerilog elaborator
package uart_sdam_pkg;
  // ----------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef logic [15:0] cnt_t;
  // ----------------------------------------------------------------
  // whole block state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] rx_sync;
    logic rx_lvl;
    logic [2:0] cts_sync;
    logic cts_lvl;
    rx_state_t rx_st;
    cnt_t rx_cnt;
    logic [3:0] rx_idx;
    logic [9:0] rx_bits;
    tx_state_t tx_st;
    cnt_t tx_cnt;
    logic [3:0] tx_idx;
    logic [10:0] tx_frame;
    logic tx_line;
    logic [7:0] tx_hold;
    logic tx_hold_mp;
    logic tx_holding_empty_flag;
    logic [7:0] rx_hold;
    logic rx_available_flag;
    logic pe;
    logic oe;
    logic fe;
    logic brk;
    logic frame_start_flag;
    logic ninth_bit_rx_flag;
    logic [1:0] spare;
    logic [7:0] node;
    logic [7:0] ctrl;
    logic selected;
    logic first_pending;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [7:0] rdata;
  } state_t;
endpackage

// [logic/uart_sdam.sv]
// serial status flags, data holding registers and node address match
// assumes a byte-wide register port on MCLK and async serial pins
`timescale 1ns/1ps
`include "uart_sdam_params.svh"

module uart_sdam #(
  parameter int unsigned CLKS_PER_BIT = `BIT_CYCLES
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic [11:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic SERIAL_IN_PIN,
  output logic SERIAL_OUT_PIN,
  input wire logic CTS_N,
  output logic IRQ
);
  import uart_sdam_pkg::*;

  localparam cnt_t BIT_LAST = cnt_t'(CLKS_PER_BIT - 1);
  localparam cnt_t HALF_LAST = cnt_t'(CLKS_PER_BIT / 2 - 1);

  state_t r;
  state_t n;
  logic rd_rx;
  logic wr_tx;
  logic extra;
  logic mode_on;
  logic [1:0] sel;
  logic rx_done;
  logic deliver;
  logic [9:0] frame;
  logic [7:0] rx_data;
  logic ext_bit;
  logic stop_bit;
  logic par_bad;
  logic brk_seen;
  logic is_addr;
  logic match;
  logic overrun;
  logic tx_idle;
  logic [3:0] rx_last;
  logic [3:0] tx_last;

  // ----------------------------------------------------------------
  // decode and frame format
  // ----------------------------------------------------------------
  // one address for both holding registers: reads go to receive side
  assign rd_rx = RD && (ADDR == `OFS_DATA);
  assign wr_tx = WR && (ADDR == `OFS_DATA);
  assign mode_on = r.ctrl[`CTRL_MODE];
  assign sel = r.ctrl[`CTRL_SEL];
  // ninth bit replaces parity in multiprocessor mode
  assign extra = mode_on | r.ctrl[`CTRL_PAR_ON];
  assign rx_last = extra ? 4'h9 : 4'h8;
  assign tx_last = extra ? 4'ha : 4'h9;
  assign tx_idle = (r.tx_st == TX_IDLE) && r.tx_holding_empty_flag;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    rx_done = 1'b0;
    deliver = 1'b0;
    // third flop vs second: a change counts once they agree
    n.rx_sync = {r.rx_sync[1:0], SERIAL_IN_PIN};
    if (r.rx_sync[1] == r.rx_sync[2]) begin
      n.rx_lvl = r.rx_sync[1];
    end
    n.cts_sync = {r.cts_sync[1:0], CTS_N};
    if (r.cts_sync[1] == r.cts_sync[2]) begin
      n.cts_lvl = r.cts_sync[1];
    end

    // receiver: middle-of-bit sampling after a checked start bit
    case (r.rx_st)
      RX_IDLE: begin
        if (!r.rx_lvl) begin
          n.rx_st = RX_START;
          n.rx_cnt = '0;
        end
      end
      RX_START: begin
        if (r.rx_cnt == HALF_LAST) begin
          n.rx_cnt = '0;
          n.rx_idx = 4'h0;
          // a glitch shorter than half a bit is dropped
          n.rx_st = r.rx_lvl ? RX_IDLE : RX_BITS;
        end else begin
          n.rx_cnt = r.rx_cnt + 16'h0001;
        end
      end
      RX_BITS: begin
        if (r.rx_cnt == BIT_LAST) begin
          n.rx_cnt = '0;
          n.rx_bits[r.rx_idx] = r.rx_lvl;
          n.rx_idx = r.rx_idx + 4'h1;
          if (r.rx_idx == rx_last) begin
            n.rx_st = RX_IDLE;
            rx_done = 1'b1;
          end
        end else begin
          n.rx_cnt = r.rx_cnt + 16'h0001;
        end
      end
      default: begin
        n.rx_st = RX_IDLE;
      end
    endcase

    frame = n.rx_bits;
    rx_data = frame[7:0];
    ext_bit = extra & frame[8];
    stop_bit = extra ? frame[9] : frame[8];
    par_bad = r.ctrl[`CTRL_PAR_ON] && !mode_on &&
              ((^{rx_data, ext_bit}) != r.ctrl[`CTRL_PAR_ODD]);
    brk_seen = ~|rx_data & ~ext_bit & ~stop_bit;
    is_addr = mode_on & ext_bit;
    match = (rx_data == r.node);

    // node filtering decides which characters reach software
    if (!mode_on) begin
      deliver = rx_done;
    end else begin
      case (sel)
        2'h0: deliver = rx_done;
        2'h1: deliver = rx_done & is_addr;
        2'h2: deliver = rx_done & (is_addr ? match : r.selected);
        default: deliver = rx_done & !is_addr & r.selected;
      endcase
    end
    overrun = deliver && r.rx_available_flag && !rd_rx;

    // clears from a holding read go first so a new character wins
    if (rd_rx) begin
      n.rx_available_flag = 1'b0;
      n.pe = 1'b0;
      n.fe = 1'b0;
      n.brk = 1'b0;
      n.frame_start_flag = 1'b0;
      n.ninth_bit_rx_flag = 1'b0;
      if (!r.rx_available_flag) begin
        n.oe = 1'b0;
      end
    end
    if (rx_done && is_addr) begin
      n.selected = match;
      n.first_pending = sel[1] ? match : 1'b1;
    end
    if (deliver) begin
      n.rx_hold = rx_data;
      n.rx_available_flag = 1'b1;
      n.pe = par_bad;
      n.fe = !stop_bit;
      n.brk = brk_seen;
      n.ninth_bit_rx_flag = ext_bit;
      n.frame_start_flag = mode_on & !is_addr & r.first_pending;
      if (overrun) begin
        n.oe = 1'b1;
      end
    end
    if (rx_done && mode_on && !is_addr) begin
      n.first_pending = 1'b0;
    end

    // transmitter: holding register feeds an 11-bit frame shifter
    case (r.tx_st)
      TX_IDLE: begin
        if (!r.tx_holding_empty_flag) begin
          n.tx_frame[0] = 1'b0;
          n.tx_frame[8:1] = r.tx_hold;
          n.tx_frame[9] = !extra | (mode_on ? r.tx_hold_mp :
                          ((^r.tx_hold) ^ r.ctrl[`CTRL_PAR_ODD]));
          n.tx_frame[10] = 1'b1;
          n.tx_line = 1'b0;
          n.tx_cnt = '0;
          n.tx_idx = 4'h0;
          n.tx_holding_empty_flag = 1'b1;
          n.tx_st = TX_SHIFT;
        end
      end
      default: begin
        if (r.tx_cnt == BIT_LAST) begin
          n.tx_cnt = '0;
          n.tx_frame = {1'b1, r.tx_frame[10:1]};
          if (r.tx_idx == tx_last) begin
            n.tx_line = 1'b1;
            n.tx_st = TX_IDLE;
          end else begin
            n.tx_line = r.tx_frame[1];
            n.tx_idx = r.tx_idx + 4'h1;
          end
        end else begin
          n.tx_cnt = r.tx_cnt + 16'h0001;
        end
      end
    endcase
    // a write while not empty overwrites the waiting byte
    if (wr_tx) begin
      n.tx_hold = WDATA;
      n.tx_hold_mp = r.ctrl[`CTRL_TXMP];
      n.tx_holding_empty_flag = 1'b0;
    end

    // ----------------------------------------------------------------
    // software writes
    // ----------------------------------------------------------------
    if (WR) begin
      if (ADDR == `OFS_CTRL) begin
        n.ctrl = WDATA;
      end else if (ADDR == `OFS_FLAGS2) begin
        n.spare = WDATA[`F2_SPARE];
      end else if (ADDR == `OFS_NODE) begin
        n.node = WDATA;
      end else if (ADDR == `OFS_IRQ_STAT) begin
        n.irq_stat = r.irq_stat & ~WDATA[3:0];
      end else if (ADDR == `OFS_IRQ_MASK) begin
        n.irq_mask = WDATA[3:0];
      end
    end
    // events after the write-one clear so a same-cycle event survives
    if (deliver) begin
      n.irq_stat[`IRQ_RX] = 1'b1;
      if (par_bad || !stop_bit || brk_seen || overrun) begin
        n.irq_stat[`IRQ_ERR] = 1'b1;
      end
    end
    if (r.tx_st == TX_IDLE && !r.tx_holding_empty_flag) begin
      n.irq_stat[`IRQ_TX_HOLDING_EMPTY_FLAG] = 1'b1;
    end
    if (r.tx_st == TX_SHIFT && n.tx_st == TX_IDLE) begin
      n.irq_stat[`IRQ_TXDONE] = 1'b1;
    end

    // ----------------------------------------------------------------
    // software reads: data stands one cycle after the strobe only
    // ----------------------------------------------------------------
    n.rdata = 8'h00;
    if (RD) begin
      if (ADDR == `OFS_DATA) begin
        n.rdata = r.rx_hold;
      end else if (ADDR == `OFS_FLAGS1) begin
        n.rdata = {r.rx_available_flag, r.pe, r.oe, r.fe, r.brk, r.tx_holding_empty_flag, tx_idle,
                   r.cts_lvl};
      end else if (ADDR == `OFS_CTRL) begin
        n.rdata = r.ctrl;
      end else if (ADDR == `OFS_FLAGS2) begin
        n.rdata = {4'h0, r.spare, r.frame_start_flag, r.ninth_bit_rx_flag};
      end else if (ADDR == `OFS_NODE) begin
        n.rdata = r.node;
      end else if (ADDR == `OFS_IRQ_STAT) begin
        n.rdata = {4'h0, r.irq_stat};
      end else if (ADDR == `OFS_IRQ_MASK) begin
        n.rdata = {4'h0, r.irq_mask};
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      r <= '0;
      r.rx_sync <= 3'h7;
      r.rx_lvl <= 1'b1;
      r.cts_sync <= 3'h7;
      r.cts_lvl <= 1'b1;
      r.tx_line <= 1'b1;
      r.tx_holding_empty_flag <= 1'b1;
      r.node <= `RST_NODE;
      r.ctrl <= `RST_CTRL;
      r.irq_mask <= `RST_MASK;
    end else begin
      r <= n;
    end
  end

  assign RDATA = r.rdata;
  assign SERIAL_OUT_PIN = r.tx_line;
  assign IRQ = |(r.irq_stat & r.irq_mask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_rda_set;
    @(posedge MCLK) disable iff (RESET)
    deliver |=> r.rx_available_flag && (r.rx_hold == $past(rx_data));
  endproperty
  a_rda_set: assert property (p_rda_set)
    else $error("available flag or data not loaded");

  property p_rda_clr;
    @(posedge MCLK) disable iff (RESET)
    rd_rx && !deliver |=> !r.rx_available_flag && !r.frame_start_flag && !r.ninth_bit_rx_flag;
  endproperty
  a_rda_clr: assert property (p_rda_clr)
    else $error("holding read did not clear flags");

  property p_pe;
    @(posedge MCLK) disable iff (RESET)
    deliver |=> r.pe == $past(par_bad);
  endproperty
  a_pe: assert property (p_pe)
    else $error("parity flag does not match character");

  property p_oe_keep;
    @(posedge MCLK) disable iff (RESET)
    rd_rx && r.rx_available_flag && r.oe |=> r.oe;
  endproperty
  a_oe_keep: assert property (p_oe_keep)
    else $error("overrun cleared while data available");

  property p_oe_set;
    @(posedge MCLK) disable iff (RESET)
    deliver && r.rx_available_flag && !rd_rx |=> r.oe;
  endproperty
  a_oe_set: assert property (p_oe_set)
    else $error("overrun not flagged");

  property p_fe_brk;
    @(posedge MCLK) disable iff (RESET)
    deliver |=> r.fe == !$past(stop_bit) && r.brk == $past(brk_seen);
  endproperty
  a_fe_brk: assert property (p_fe_brk)
    else $error("framing or break flag wrong");

  property p_tx_holding_empty_flag;
    @(posedge MCLK) disable iff (RESET)
    wr_tx && r.tx_holding_empty_flag && r.tx_st == TX_IDLE |=> !r.tx_holding_empty_flag ##1 r.tx_holding_empty_flag;
  endproperty
  a_tx_holding_empty_flag: assert property (p_tx_holding_empty_flag)
    else $error("holding empty flag sequence wrong");

  property p_tx_start;
    @(posedge MCLK) disable iff (RESET)
    r.tx_st == TX_IDLE && !r.tx_holding_empty_flag |=> !SERIAL_OUT_PIN && !tx_idle;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("start bit not driven");

  property p_cts;
    @(posedge MCLK) disable iff (RESET)
    RD && ADDR == `OFS_FLAGS1 |=> RDATA[0] == $past(r.cts_lvl);
  endproperty
  a_cts: assert property (p_cts)
    else $error("clear-to-send level not reported");

  property p_nomatch;
    @(posedge MCLK) disable iff (RESET)
    rx_done && mode_on && sel[1] && is_addr && !match |-> !deliver;
  endproperty
  a_nomatch: assert property (p_nomatch)
    else $error("mismatched address delivered");
endmodule

// [test/serial_node.sv]
// remote serial node: drives the block's receive line, samples its output
// assumes an idle-high line and cpb system clocks for every bit
`timescale 1ns/1ps
module serial_node #(
  parameter int CPB = 8
) (
  input wire logic mclk,
  output logic line_out,
  input wire logic line_in
);
  // idle level between frames is the line's resting high
  initial line_out = 1'b1;
  // ----------------------------------------------------------------
  // send one character, lsb first; has9 adds a ninth or parity bit
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] v, input logic b9,
                      input logic has9, input logic stp);
    logic [10:0] f;
    int n;
    n = has9 ? 11 : 10;
    f = has9 ? {stp, b9, v, 1'b0} : {1'b1, stp, v, 1'b0};
    for (int i = 0; i < n; i++) begin
      line_out <= f[i];
      repeat (CPB) @(posedge mclk);
    end
    // one idle clock so a following frame never shares this time step
    line_out <= 1'b1;
    @(posedge mclk);
  endtask
  // ----------------------------------------------------------------
  // receive one character; sampled in mid-bit, returns in stop bit
  // ----------------------------------------------------------------
  task automatic get(output logic [7:0] v);
    @(negedge line_in);
    repeat (CPB + CPB / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      v[i] = line_in;
      repeat (CPB) @(posedge mclk);
    end
  endtask
endmodule

// [test/uart_sdam_tb.sv]
// self-checking bench for the serial status and node match block
// assumes the remote node model and an 8-clock bit time
`timescale 1ns/1ps
`include "uart_sdam_params.svh"
module uart_sdam_tb;
  localparam int CPB = 8;
  logic MCLK = 1'b0;
  logic RESET = 1'b1;
  logic [11:0] ADDR = 12'h000;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic CTS_N = 1'b1;
  logic [7:0] RDATA;
  logic SERIAL_IN_PIN;
  logic SERIAL_OUT_PIN;
  logic IRQ;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [7:0] d;
  logic [7:0] d2;
  logic [11:0] za [5] = '{12'hf42, 12'hf44, 12'hf45, 12'hf49, 12'hf4f};

  always #5 MCLK = ~MCLK;

  uart_sdam #(.CLKS_PER_BIT(CPB)) i_uart_sdam (
    .MCLK(MCLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SERIAL_IN_PIN(SERIAL_IN_PIN),
    .SERIAL_OUT_PIN(SERIAL_OUT_PIN), .CTS_N(CTS_N), .IRQ(IRQ));
  serial_node #(.CPB(CPB)) i_serial_node (
    .mclk(MCLK), .line_out(SERIAL_IN_PIN), .line_in(SERIAL_OUT_PIN));

  // ----------------------------------------------------------------
  // bus access and comparison
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  // one character in, then the primary flags compared
  task automatic rx(input logic [7:0] v, input logic b9, input logic h9,
                    input logic stp, input logic [7:0] f1);
    logic [7:0] r;
    i_serial_node.send(v, b9, h9, stp);
    repeat (6) @(posedge MCLK);
    rd(`OFS_FLAGS1, r);
    chk(r, f1);
  endtask
  // a frame with a low stop bit may look like a new start: flush it
  task automatic drain;
    logic [7:0] r;
    repeat (12 * CPB) @(posedge MCLK);
    rd(`OFS_DATA, r);
    rd(`OFS_DATA, r);
  endtask
  // ninth-bit mode character; delivery, status and data compared
  task automatic mp(input logic [7:0] c, input logic [7:0] v,
                    input logic nb, input logic ra, input logic [7:0] f2);
    logic [7:0] r;
    wr(`OFS_CTRL, c);
    rx(v, nb, 1'b1, 1'b1, {ra, 7'h07});
    rd(`OFS_FLAGS2, r);
    chk(r, f2);
    if (ra) begin
      rd(`OFS_DATA, r);
      chk(r, v);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: whole sequence needs well under 10000 cycles
  // ----------------------------------------------------------------
  initial begin
    #400000;
    n_mismatch++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge MCLK);
    RESET <= 1'b0;
    rd(`OFS_FLAGS1, d);
    chk(d, 8'h07);
    for (int i = 0; i < 5; i++) begin
      rd(za[i], d);
      chk(d, 8'h00);
    end
    @(posedge MCLK);
    CTS_N <= 1'b0;
    repeat (6) @(posedge MCLK);
    rd(`OFS_FLAGS1, d);
    chk(d, 8'h06);
    CTS_N <= 1'b1;
    repeat (6) @(posedge MCLK);
    wr(`OFS_FLAGS2, 8'h00);
    rd(`OFS_FLAGS2, d);
    chk(d, 8'h00);
    wr(`OFS_FLAGS2, 8'h00);
    wr(`OFS_NODE, 8'h42);
    rd(`OFS_NODE, d);
    chk(d, 8'h42);
    $display("test registers done");
    rx(8'ha5, 1'b0, 1'b0, 1'b1, 8'h87);
    rd(`OFS_DATA, d);
    chk(d, 8'ha5);
    rd(`OFS_FLAGS1, d);
    chk(d, 8'h07);
    wr(`OFS_CTRL, 8'h01);
    rx(8'h03, 1'b1, 1'b1, 1'b1, 8'hc7);
    rd(`OFS_DATA, d);
    chk(d, 8'h03);
    rd(`OFS_FLAGS1, d);
    chk(d, 8'h07);
    wr(`OFS_CTRL, 8'h03);
    rx(8'h03, 1'b1, 1'b1, 1'b1, 8'h87);
    rd(`OFS_DATA, d);
    wr(`OFS_CTRL, 8'h00);
    rx(8'h55, 1'b0, 1'b0, 1'b0, 8'h97);
    rd(`OFS_DATA, d);
    rd(`OFS_FLAGS1, d);
    chk(d, 8'h07);
    drain();
    rx(8'h00, 1'b0, 1'b0, 1'b0, 8'h9f);
    rd(`OFS_DATA, d);
    rd(`OFS_FLAGS1, d);
    chk(d, 8'h07);
    drain();
    i_serial_node.send(8'h11, 1'b0, 1'b0, 1'b1);
    rx(8'h22, 1'b0, 1'b0, 1'b1, 8'ha7);
    rd(`OFS_DATA, d);
    rd(`OFS_FLAGS1, d);
    chk(d, 8'h27);
    rd(`OFS_DATA, d);
    rd(`OFS_FLAGS1, d);
    chk(d, 8'h07);
    $display("test receive flags done");
    fork
      i_serial_node.get(d2);
      begin
        wr(`OFS_DATA, 8'h3c);
        repeat (5) @(posedge MCLK);
        rd(`OFS_FLAGS1, d);
        chk(d, 8'h05);
      end
    join
    chk(d2, 8'h3c);
    // still inside the stop bit: the shifter is not done yet
    rd(`OFS_FLAGS1, d);
    chk(d, 8'h05);
    repeat (2 * CPB) @(posedge MCLK);
    rd(`OFS_FLAGS1, d);
    chk(d, 8'h07);
    $display("test transmit done");
    mp(8'h14, 8'h17, 1'b1, 1'b0, 8'h00);
    mp(8'h14, 8'h42, 1'b1, 1'b1, 8'h01);
    mp(8'h14, 8'h99, 1'b0, 1'b1, 8'h02);
    mp(8'h14, 8'h17, 1'b1, 1'b0, 8'h00);
    mp(8'h14, 8'h55, 1'b0, 1'b0, 8'h00);
    mp(8'h1c, 8'h42, 1'b1, 1'b0, 8'h00);
    mp(8'h1c, 8'h66, 1'b0, 1'b1, 8'h02);
    mp(8'h1c, 8'h67, 1'b0, 1'b1, 8'h00);
    mp(8'h0c, 8'h22, 1'b0, 1'b0, 8'h00);
    mp(8'h0c, 8'h05, 1'b1, 1'b1, 8'h01);
    mp(8'h04, 8'h07, 1'b1, 1'b1, 8'h01);
    mp(8'h04, 8'h33, 1'b0, 1'b1, 8'h02);
    $display("test node match done");
    wr(`OFS_CTRL, 8'h00);
    wr(`OFS_IRQ_MASK, 8'h00);
    wr(`OFS_IRQ_STAT, 8'h0f);
    rx(8'h77, 1'b0, 1'b0, 1'b1, 8'h87);
    chk({7'h00, IRQ}, 8'h00);
    rd(`OFS_IRQ_STAT, d);
    chk(d, 8'h01);
    wr(`OFS_IRQ_MASK, 8'h01);
    repeat (2) @(posedge MCLK);
    chk({7'h00, IRQ}, 8'h01);
    wr(`OFS_IRQ_STAT, 8'h01);
    repeat (2) @(posedge MCLK);
    chk({7'h00, IRQ}, 8'h00);
    rd(`OFS_DATA, d);
    chk(d, 8'h77);
    $display("test interrupt done");
    complete_run();
  end
endmodule
